// ---- inc/sdb_pkg.sv ----
// Package: register map, field layout, reset values and timing constants
// Assumes a 100 MHz core clock and a single AHB-Lite master
package sdb_pkg;

  // ***********************************************************
  // Clock and time base
  // ***********************************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  // Time settings are held in units of 0.1 s
  localparam int unsigned TIME_TICK_MS    = 100;
  localparam int unsigned TICK_CYCLES     = (CLK_HZ / 1000) * TIME_TICK_MS;
  // Ramp step period, 1 ms
  localparam int unsigned RAMP_STEP_US    = 1000;
  localparam int unsigned RAMP_CYCLES     = (CLK_HZ / 1_000_000) * RAMP_STEP_US;
  // Braking unit PWM frame, in cycles (one percent per cycle)
  localparam int unsigned DUTY_PERIOD     = 100;

  // ***********************************************************
  // Register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFS_CTRL         = 8'h00;
  localparam logic [7:0] OFS_FREQ         = 8'h04;
  localparam logic [7:0] OFS_DECEL        = 8'h08;
  localparam logic [7:0] OFS_BRK_FREQ     = 8'h0c;
  localparam logic [7:0] OFS_BRK_WAIT     = 8'h10;
  localparam logic [7:0] OFS_BRK_CUR      = 8'h14;
  localparam logic [7:0] OFS_BRK_HOLD     = 8'h18;
  localparam logic [7:0] OFS_DUTY         = 8'h1c;
  localparam logic [7:0] OFS_RATING       = 8'h20;
  localparam logic [7:0] OFS_STATUS       = 8'h24;
  localparam logic [7:0] OFS_OUTFREQ      = 8'h28;

  // ***********************************************************
  // Control register fields
  // ***********************************************************
  localparam int unsigned CTRL_RUN_BIT    = 0;
  localparam int unsigned CTRL_STOP_BIT   = 1;
  localparam int unsigned CTRL_MODE_BIT   = 2;
  localparam int unsigned CTRL_UNIT_BIT   = 3;

  // ***********************************************************
  // Reset values
  // ***********************************************************
  localparam logic        RST_MODE        = 1'b0;
  localparam logic [15:0] RST_BRK_FREQ    = 16'h0000;
  localparam logic [8:0]  RST_BRK_WAIT    = 9'h000;
  localparam logic [6:0]  RST_BRK_CUR     = 7'h00;
  localparam logic [8:0]  RST_BRK_HOLD    = 9'h000;
  localparam logic [6:0]  RST_DUTY        = 7'h64;
  localparam logic [15:0] RST_DECEL       = 16'h0001;
  localparam logic [15:0] RST_RATING      = 16'h0000;
  // Base current limit, percent of drive rating
  localparam int unsigned BASE_LIMIT_PCT  = 80;

  // ***********************************************************
  // Sequencer states
  // ***********************************************************
  typedef enum logic [2:0] {
    SDB_IDLE,
    SDB_RUN,
    SDB_RAMP,
    SDB_WAIT,
    SDB_BRAKE,
    SDB_COAST
  } sdb_state_e;

endpackage : sdb_pkg

// ---- design/sdb_timer.sv ----
// Countdown timer in 0.1 s ticks
// Assumes a synchronous active-high reset and a one-cycle load pulse
module sdb_timer
  import sdb_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES,
  parameter int unsigned TW   = 9
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          load,
  input  wire logic [TW-1:0] ticks,
  output logic               busy
);

  logic [26:0]   pre_q;
  logic [TW-1:0] cnt_q;
  wire           pre_end = (pre_q == 27'(TICK - 1));

  always_ff @(posedge clk) begin
    if (rst || load || !busy) begin
      pre_q <= '0;
    end else if (pre_end) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 27'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= ticks;
    end else if (busy && pre_end) begin
      cnt_q <= cnt_q - TW'(1);
    end
  end

  assign busy = (cnt_q != '0);

endmodule : sdb_timer

// ---- design/sdb_duty_pwm.sv ----
// Braking unit PWM with percent duty
// Assumes duty in 0..100; values above 100 act as full on
module sdb_duty_pwm
  import sdb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic [6:0] duty,
  output logic            pwm_q
);

  logic [6:0] ph_q;
  wire        ph_end = (ph_q == 7'(DUTY_PERIOD - 1));

  always_ff @(posedge clk) begin
    if (rst || ph_end) begin
      ph_q <= '0;
    end else begin
      ph_q <= ph_q + 7'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= en && (ph_q < duty);
    end
  end

endmodule : sdb_duty_pwm

// ---- design/sdb_stop_brake.sv ----
// Stop and DC-brake sequencer with AHB-Lite register slave
// Assumes one AHB-Lite master, word transfers, and a 100 MHz CORE_CLK
// Operation
// - Mode 0 stop ramps frequency down at decel rate, then stopped.
// - Mode 1 stop disables output at once; motor coasts.
// - During ramp, start braking once frequency falls below start threshold.
// - At threshold, suppress output for waiting interval before DC braking.
// - Brake current is percent of min(motor rated, 80% drive rated).
// - Hold DC braking for set duration; zero duration skips braking.
// - Internal braking unit driven at set duty; ignored if unit absent.
module sdb_stop_brake
  import sdb_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES,
  parameter int unsigned STEP = RAMP_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        SYS_RST,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HSEL,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic [15:0]      OUT_FREQ,
  output logic             OUT_ENABLE,
  output logic             DC_BRAKE_ON,
  output logic [15:0]      DC_BRAKE_LEVEL,
  output logic             BRAKE_UNIT_PWM
);
  import sdb_pkg::*;

  // ***********************************************************
  // AHB-Lite slave
  // ***********************************************************
  logic        wr_q;
  logic [7:0]  wa_q;
  logic [31:0] rdata_q;
  wire         a_valid  = HSEL && HREADY && HTRANS[1];
  wire         a_write  = a_valid && HWRITE;
  wire         a_read   = a_valid && !HWRITE;
  wire [7:0]   a_addr   = HADDR[7:0];
  wire         wr_ctrl  = wr_q && (wa_q == OFS_CTRL);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      wr_q <= 1'b0;
      wa_q <= '0;
    end else begin
      wr_q <= a_write;
      wa_q <= a_addr;
    end
  end

  // ***********************************************************
  // Parameter registers
  // ***********************************************************
  logic        mode_q;
  logic        unit_q;
  logic [15:0] freq_set_q;
  logic [15:0] decel_q;
  logic [15:0] brk_freq_q;
  logic [8:0]  brk_wait_q;
  logic [6:0]  brk_cur_q;
  logic [8:0]  brk_hold_q;
  logic [6:0]  duty_q;
  logic [15:0] motor_i_q;
  logic [15:0] drive_i_q;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_q     <= RST_MODE;
      unit_q     <= 1'b0;
      freq_set_q <= '0;
      decel_q    <= RST_DECEL;
      brk_freq_q <= RST_BRK_FREQ;
      brk_wait_q <= RST_BRK_WAIT;
      brk_cur_q  <= RST_BRK_CUR;
      brk_hold_q <= RST_BRK_HOLD;
      duty_q     <= RST_DUTY;
      motor_i_q  <= RST_RATING;
      drive_i_q  <= RST_RATING;
    end else if (wr_q) begin
      unique case (wa_q)
        OFS_CTRL: begin
          mode_q <= HWDATA[CTRL_MODE_BIT];
          unit_q <= HWDATA[CTRL_UNIT_BIT];
        end
        OFS_FREQ:     freq_set_q <= HWDATA[15:0];
        OFS_DECEL:    decel_q    <= HWDATA[15:0];
        OFS_BRK_FREQ: brk_freq_q <= HWDATA[15:0];
        OFS_BRK_WAIT: brk_wait_q <= (HWDATA[8:0] > 9'd360) ? 9'd360 : HWDATA[8:0];
        OFS_BRK_CUR:  brk_cur_q  <= (HWDATA[6:0] > 7'd100) ? 7'd100 : HWDATA[6:0];
        OFS_BRK_HOLD: brk_hold_q <= (HWDATA[8:0] > 9'd360) ? 9'd360 : HWDATA[8:0];
        OFS_DUTY:     duty_q     <= (HWDATA[6:0] > 7'd100) ? 7'd100 : HWDATA[6:0];
        OFS_RATING: begin
          motor_i_q <= HWDATA[15:0];
          drive_i_q <= HWDATA[31:16];
        end
        default: ;
      endcase
    end
  end

  wire run_cmd  = wr_ctrl && HWDATA[CTRL_RUN_BIT];
  wire stop_cmd = wr_ctrl && HWDATA[CTRL_STOP_BIT];
  // Mode written together with the stop applies to that stop
  wire mode_now = wr_ctrl ? HWDATA[CTRL_MODE_BIT] : mode_q;

  // ***********************************************************
  // Sequencer
  // ***********************************************************
  sdb_state_e  st_q;
  sdb_state_e  st_d;
  logic [15:0] freq_q;
  logic [15:0] freq_d;
  logic [31:0] step_q;
  logic        tmr_load;
  logic [8:0]  tmr_ticks;
  logic        tmr_busy;

  wire step_end  = (step_q == 32'(STEP - 1));
  wire [15:0] freq_dn = (freq_q > decel_q) ? (freq_q - decel_q) : 16'h0000;
  wire below_thr = (freq_dn < brk_freq_q);
  wire has_hold  = (brk_hold_q != '0);
  wire has_wait  = (brk_wait_q != '0);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST || step_end) begin
      step_q <= '0;
    end else begin
      step_q <= step_q + 32'd1;
    end
  end

  always_comb begin
    st_d      = st_q;
    freq_d    = freq_q;
    tmr_load  = 1'b0;
    tmr_ticks = '0;
    unique case (st_q)
      SDB_IDLE: begin
        freq_d = '0;
        if (run_cmd && !stop_cmd) begin
          st_d = SDB_RUN;
        end
      end
      SDB_RUN: begin
        freq_d = freq_set_q;
        if (stop_cmd) begin
          if (mode_now) begin
            st_d   = SDB_COAST;
            freq_d = '0;
          end else begin
            st_d = SDB_RAMP;
          end
        end
      end
      SDB_RAMP: begin
        if (step_end) begin
          freq_d = freq_dn;
          if (has_hold && below_thr) begin
            if (has_wait) begin
              st_d      = SDB_WAIT;
              tmr_load  = 1'b1;
              tmr_ticks = brk_wait_q;
            end else begin
              st_d      = SDB_BRAKE;
              tmr_load  = 1'b1;
              tmr_ticks = brk_hold_q;
            end
            freq_d = '0;
          end else if (freq_dn == '0) begin
            st_d = SDB_IDLE;
          end
        end
      end
      SDB_WAIT: begin
        if (!tmr_busy) begin
          st_d      = SDB_BRAKE;
          tmr_load  = 1'b1;
          tmr_ticks = brk_hold_q;
        end
      end
      SDB_BRAKE: begin
        if (!tmr_busy && !tmr_load) begin
          st_d = SDB_IDLE;
        end
      end
      SDB_COAST: begin
        st_d = SDB_IDLE;
      end
      default: st_d = SDB_IDLE;
    endcase
  end

  logic brk_arm_q;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      st_q      <= SDB_IDLE;
      freq_q    <= '0;
      brk_arm_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      freq_q    <= freq_d;
      brk_arm_q <= tmr_load;
    end
  end

  sdb_timer #(
    .TICK (TICK),
    .TW   (9)
  ) u_timer (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .load  (tmr_load),
    .ticks (tmr_ticks),
    .busy  (tmr_busy)
  );

  // ***********************************************************
  // Brake current and outputs
  // ***********************************************************
  // base current
  wire [31:0] lim_x   = 32'(drive_i_q) * 32'(BASE_LIMIT_PCT);
  wire [31:0] mot_x   = 32'(motor_i_q) * 32'd100;
  wire [15:0] base_i  = (mot_x <= lim_x) ? motor_i_q : 16'(lim_x / 32'd100);
  wire [31:0] lvl_x   = 32'(base_i) * 32'(brk_cur_q);
  wire [15:0] lvl     = 16'(lvl_x / 32'd100);
  wire        braking = (st_q == SDB_BRAKE) && !brk_arm_q ? tmr_busy : (st_q == SDB_BRAKE);
  wire        drive   = (st_q == SDB_RUN) || (st_q == SDB_RAMP);
  wire        unit_en = unit_q && drive && (st_q == SDB_RAMP);
  logic [31:0] rd_mux;

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      OUT_FREQ       <= '0;
      OUT_ENABLE     <= 1'b0;
      DC_BRAKE_ON    <= 1'b0;
      DC_BRAKE_LEVEL <= '0;
    end else begin
      OUT_FREQ       <= freq_q;
      OUT_ENABLE     <= drive;
      DC_BRAKE_ON    <= braking;
      DC_BRAKE_LEVEL <= braking ? lvl : 16'h0000;
    end
  end

  sdb_duty_pwm u_pwm (
    .clk   (CORE_CLK),
    .rst   (SYS_RST),
    .en    (unit_en),
    .duty  (duty_q),
    .pwm_q (BRAKE_UNIT_PWM)
  );

  // ***********************************************************
  // Read data
  // ***********************************************************
  always_comb begin
    unique case (a_addr)
      OFS_CTRL:     rd_mux = {28'h0, unit_q, mode_q, 2'b00};
      OFS_FREQ:     rd_mux = {16'h0, freq_set_q};
      OFS_DECEL:    rd_mux = {16'h0, decel_q};
      OFS_BRK_FREQ: rd_mux = {16'h0, brk_freq_q};
      OFS_BRK_WAIT: rd_mux = {23'h0, brk_wait_q};
      OFS_BRK_CUR:  rd_mux = {25'h0, brk_cur_q};
      OFS_BRK_HOLD: rd_mux = {23'h0, brk_hold_q};
      OFS_DUTY:     rd_mux = {25'h0, duty_q};
      OFS_RATING:   rd_mux = {drive_i_q, motor_i_q};
      OFS_STATUS:   rd_mux = {29'h0, st_q};
      OFS_OUTFREQ:  rd_mux = {16'h0, freq_q};
      default:      rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      rdata_q <= '0;
    end else if (a_read) begin
      rdata_q <= rd_mux;
    end
  end

  // Zero wait states, always OKAY, both taken from flops
  logic rdy_q;
  logic resp_q;

  always_ff @(posedge CORE_CLK) begin
    rdy_q  <= 1'b1;
    resp_q <= 1'b0;
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = rdy_q;
  assign HRESP     = resp_q;

endmodule : sdb_stop_brake

// ---- verif/sdb_power_stage.sv ----
// Partner model: power stage and braking unit seen from the sequencer outputs
// Assumes one clock; clr restarts every measurement
module sdb_power_stage (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        dc,
  input  wire logic        pwm,
  input  wire logic [15:0] lvl,
  output int               gap,
  output int               brk,
  output int               pwm_n,
  output logic [15:0]      lvl_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Measurements
  // ****************************************
  logic armed;
  always @(posedge clk) begin
    if (clr) begin
      gap <= 0;
      brk <= 0;
      pwm_n <= 0;
      lvl_q <= 16'h0000;
      armed <= 1'b0;
    end else begin
      armed <= armed | en;
      if (armed && !en && !dc && brk == 0) gap <= gap + 1;
      if (dc) begin
        brk <= brk + 1;
        lvl_q <= lvl;
      end
      if (pwm) pwm_n <= pwm_n + 1;
    end
  end
endmodule : sdb_power_stage

// ---- verif/sdb_stop_brake_asserts.sv ----
// Checker: bus answer and stop/brake output relations
// Assumes binding into sdb_stop_brake, one clock domain
module sdb_stop_brake_asserts
  import sdb_pkg::*;
#(
  parameter int unsigned TICK = TICK_CYCLES
) (
  input wire logic        CORE_CLK,
  input wire logic        SYS_RST,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HSEL,
  input wire logic        HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        OUT_ENABLE,
  input wire logic        DC_BRAKE_ON,
  input wire logic [15:0] DC_BRAKE_LEVEL,
  input wire logic        BRAKE_UNIT_PWM
);
  // ****************************************
  // Helpers and properties
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  logic        ctrl_wr_q;
  int unsigned brk_cnt_q;
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ctrl_wr_q <= 1'b0;
      brk_cnt_q <= 0;
    end else begin
      ctrl_wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:0] == OFS_CTRL;
      brk_cnt_q <= DC_BRAKE_ON ? brk_cnt_q + 1 : 0;
    end
  end
  sequence s_stop_coast;
    ctrl_wr_q && HWDATA[1] && HWDATA[2];
  endsequence
  sequence s_brake_fall;
    $fell(DC_BRAKE_ON);
  endsequence
  property p_ready;
    HREADYOUT && !HRESP;
  endproperty
  property p_coast;
    s_stop_coast |-> ##[1:3] !OUT_ENABLE && !DC_BRAKE_ON;
  endproperty
  property p_excl;
    DC_BRAKE_ON |-> !OUT_ENABLE && !BRAKE_UNIT_PWM;
  endproperty
  property p_zero_lvl;
    !DC_BRAKE_ON && !$past(DC_BRAKE_ON) |-> DC_BRAKE_LEVEL == 16'h0000;
  endproperty
  property p_lvl_hold;
    DC_BRAKE_ON && $past(DC_BRAKE_ON) && $past(DC_BRAKE_ON, 2) |-> $stable(DC_BRAKE_LEVEL);
  endproperty
  property p_pwm_ramp;
    BRAKE_UNIT_PWM |-> OUT_ENABLE;
  endproperty
  property p_hold_min;
    s_brake_fall |-> brk_cnt_q + 1 >= TICK;
  endproperty
  property p_after_brake;
    s_brake_fall |-> !OUT_ENABLE [*3];
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
  a_coast: assert property (p_coast) else $error("coast stop kept driving");
  a_excl: assert property (p_excl) else $error("brake while driving");
  a_zero_lvl: assert property (p_zero_lvl) else $error("brake level outside braking");
  a_lvl_hold: assert property (p_lvl_hold) else $error("brake level moved");
  a_pwm_ramp: assert property (p_pwm_ramp) else $error("unit gate outside ramp");
  a_hold_min: assert property (p_hold_min) else $error("brake shorter than one tick");
  a_after_brake: assert property (p_after_brake) else $error("drive after braking");
endmodule : sdb_stop_brake_asserts

bind sdb_stop_brake sdb_stop_brake_asserts #(.TICK(TICK)) i_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HSEL(HSEL), .HREADY(HREADY), .HWDATA(HWDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OUT_ENABLE(OUT_ENABLE),
  .DC_BRAKE_ON(DC_BRAKE_ON), .DC_BRAKE_LEVEL(DC_BRAKE_LEVEL),
  .BRAKE_UNIT_PWM(BRAKE_UNIT_PWM)
);

// ---- verif/sdb_stop_brake_tb_top.sv ----
// Testbench: AHB-Lite master, stop sequences against an integer model
// Assumes shortened TICK and STEP; HREADYOUT feeds HREADY
module sdb_stop_brake_tb_top;
  import sdb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned TK = 20;
  localparam int unsigned ST = 4;
  logic        clk, rst, hwrite, hsel, hready, en, dc, pwm, clr;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic [15:0] lvl, lvl_q, ofreq;
  int          gap, brk, pwm_n, n_mismatch, checked;
  logic [7:0]  ra [6] = '{OFS_DUTY, OFS_BRK_FREQ, OFS_BRK_WAIT, OFS_BRK_CUR, OFS_BRK_HOLD, 8'h40};
  logic [31:0] rv [6] = '{32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  sdb_stop_brake #(.TICK(TK), .STEP(ST)) i_dut (
    .CORE_CLK(clk), .SYS_RST(rst), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HSEL(hsel), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .OUT_FREQ(ofreq), .OUT_ENABLE(en), .DC_BRAKE_ON(dc),
    .DC_BRAKE_LEVEL(lvl), .BRAKE_UNIT_PWM(pwm));
  sdb_power_stage i_stage (.clk(clk), .clr(clr), .en(en), .dc(dc), .pwm(pwm), .lvl(lvl),
    .gap(gap), .brk(brk), .pwm_n(pwm_n), .lvl_q(lvl_q));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  task automatic hwait();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      summarize();
    end
  endtask : hwait
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsel <= 1'b1;
    hwait();
    htrans <= 2'b00;
    hwdata <= d;
    hwait();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask : wr
  task automatic scen(input int md, un, f, dec, bf, wt, hd, cur, m, d, dy);
    int k, n, lv, base, eb;
    logic b;
    b = md == 0 && hd != 0 && bf != 0;
    base = (m * 100 <= d * 80) ? m : d * 80 / 100;
    lv = b ? cur * base / 100 : 0;
    eb = b ? hd * TK : 0;
    k = md == 0 ? 0 : -1;
    while (md == 0 && f - (k + 1) * dec >= (b ? bf : 1)) k++;
    wr(OFS_FREQ, f);
    wr(OFS_DECEL, dec);
    wr(OFS_BRK_FREQ, bf);
    wr(OFS_BRK_WAIT, wt);
    wr(OFS_BRK_HOLD, hd);
    wr(OFS_BRK_CUR, cur);
    wr(OFS_RATING, {d[15:0], m[15:0]});
    wr(OFS_DUTY, dy);
    clr <= 1'b1;
    wr(OFS_CTRL, {28'h0, un[0], md[0], 2'b01});
    clr <= 1'b0;
    repeat (20) @(posedge clk);
    chk("run freq", ofreq, f);
    wr(OFS_CTRL, {28'h0, un[0], md[0], 2'b10});
    n = 0;
    while (en !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("ramp", n + ST + 3 >= (k + 1) * ST && n <= (k + 1) * ST + ST + 3, 32'h1);
    if (n >= 5000) summarize();
    chk("stop freq", ofreq, 32'h0);
    n = 0;
    do begin
      bus(OFS_STATUS, 1'b0, 32'h0, rd);
      n++;
    end while (rd !== 32'h0 && n < 500);
    chk("status", rd, 32'h0);
    if (n >= 500) summarize();
    chk("level", lvl_q, lv);
    chk("hold", brk + 2 >= eb && brk <= eb + 2, 32'h1);
    if (b) chk("gap", gap + 2 >= wt * TK && gap <= wt * TK + 2, 32'h1);
    chk("pwm", pwm_n != 0, md == 0 && un != 0 && dy != 0);
  endtask : scen
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    clr = 1'b1;
    n_mismatch = 0;
    checked = 0;
    seed = 32'h7eac;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(8'h40, seed);
    for (int i = 0; i < 6; i++) begin
      bus(ra[i], 1'b0, 32'h0, rd);
      chk("reset value", rd, rv[i]);
    end
    seed = lfsr(seed);
    scen(0, 1, 200 + seed % 300, 5, 0, 2, 3, 40, 100, 500, 1 + lfsr(seed) % 100);
    scen(0, 1, 100, 10, 35, 2, 3, 50, 200, 1000, 0);
    scen(0, 0, 100, 10, 35, 0, 1, 25, 900, 1000, 100);
    scen(0, 1, 100, 10, 35, 2, 0, 50, 200, 1000, 100);
    scen(1, 1, 100, 10, 35, 2, 3, 50, 200, 1000, 100);
    summarize();
  end
endmodule : sdb_stop_brake_tb_top
